// file: verilog/itm_timer_regs.vh
// register offsets, field layouts and encodings of the interval timer
`ifndef ITM_TIMER_REGS_VH
`define ITM_TIMER_REGS_VH

// port addresses on {PORT_SELECT_HIGH, PORT_SELECT_LOW}
`define ITM_ADDR_CNT0     2'h0
`define ITM_ADDR_CNT1     2'h1
`define ITM_ADDR_CNT2     2'h2
`define ITM_ADDR_CTL      2'h3

// mode command word fields
`define ITM_CW_SEL        7:6
`define ITM_CW_RW         5:4
`define ITM_CW_MODE       3:1
`define ITM_CW_BCD        0
`define ITM_CW_KEEP       5:0
`define ITM_SEL_READBACK  2'h3

// byte formats
`define ITM_RW_LATCH      2'h0
`define ITM_RW_LSB        2'h1
`define ITM_RW_MSB        2'h2
`define ITM_RW_BOTH       2'h3

// count modes
`define ITM_MODE0         3'h0
`define ITM_MODE1         3'h1
`define ITM_MODE2         3'h2
`define ITM_MODE3         3'h3
`define ITM_MODE4         3'h4
`define ITM_MODE5         3'h5

// read-back command fields (count and status bits are active low)
`define ITM_RB_NCOUNT     5
`define ITM_RB_NSTATUS    4
`define ITM_RB_CNT0       1

// counter constants and reset values
`define ITM_CNT_ONE       16'h0001
`define ITM_CNT_TWO       16'h0002
`define ITM_CNT_RST       16'h0000
`define ITM_CTL_RST       6'h00
`define ITM_BYTE_ZERO     8'h00
`define ITM_STEP_ONE      2'h1
`define ITM_STEP_TWO      2'h2
`define ITM_BCD_TEN       5'h0A
`define ITM_BCD_DIGITS    4

`endif

// file: verilog/itm_dcnt.v
// sixteen-bit presettable down-counter with binary or decimal stepping
`include "itm_timer_regs.vh"

module itm_dcnt (
   clk,
   rst_n,
   load,
   dec,
   step,
   bcd,
   load_val,
   cnt
);
   input  wire        clk;
   input  wire        rst_n;
   input  wire        load;
   input  wire        dec;
   input  wire [1:0]  step;
   input  wire        bcd;
   input  wire [15:0] load_val;
   output reg  [15:0] cnt;

   wire [15:0] bin_next;
   wire [15:0] bcd_next;
   wire [4:0]  borrow;

   // binary step wraps from zero to the top of the range
   // RQ16: zero is full range
   assign bin_next  = cnt - {14'h0000, step};
   assign borrow[0] = 1'b0;

   // decimal step, one digit per loop pass, borrow rippling upward
   genvar d;
   generate
      for (d = 0; d < `ITM_BCD_DIGITS; d = d + 1) begin : g_digit
         wire [4:0] sub;
         wire [4:0] diff;
         assign sub  = (d == 0) ? {3'h0, step} : {4'h0, borrow[d]};
         assign diff = {1'b0, cnt[d*4 +: 4]} - sub;
         assign borrow[d+1] = diff[4];
         assign bcd_next[d*4 +: 4] = diff[4] ? (diff[3:0] + 4'hA) : diff[3:0];
      end
   endgenerate

   // load wins over a decrement in the same pulse
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= `ITM_CNT_RST;
      end else if (load) begin
         cnt <= load_val;
      end else if (dec) begin
         cnt <= bcd ? bcd_next : bin_next;
      end
   end
endmodule // itm_dcnt

// file: verilog/itm_timer.v
// three-channel interval timer with byte-wide bus port and six count modes
//
// Summary of operation
// RQ1: host writes a counter's mode word before its count; any counter order works.
// RQ2: host writes counts in the byte format chosen by the mode word.
// RQ3: address 0-2 reads or writes counters, 3 writes mode; others float the bus.
// RQ4: unlatched reads follow byte format; host stops clock or gate for stability.
// RQ5: latch command freezes counter value until read or reprogrammed; counting continues.
// RQ6: second latch command before the first is read is ignored.
// RQ7: in two-byte format the host reads both latched bytes.
// RQ8: read and write byte toggles are kept independent of each other.
// RQ9: read-back latches status: mode word, output level, null-count flag.
// RQ10: repeated status or count latch while still unread is ignored.
// RQ11: read-back with both active-low bits clear latches count and status together.
// RQ12: with both latched, status reads first, then one or two count bytes.
// RQ13: writing a mode word sets the output to that mode's initial level at once.
// RQ14: gate sampled at counter clock rise; level, edge, or both per mode.
// RQ15: count loading and decrements happen on counter clock falling edges.
// RQ16: an initial count of zero acts as the full range, binary or decimal.
// RQ17: modes 0,1,4,5 wrap past zero; modes 2,3 reload at terminal count.
// RQ18: mode 0 output low from setting until terminal count, then high.
// RQ19: in mode 0 the gate pauses counting and never touches the output.
// RQ20: in mode 0 the count loads on the first clock pulse after writing.
// RQ21: mode 0 first byte suspends counting, output low; second byte restarts.
// RQ22: mode 1 output high; trigger loads and drives low; high at terminal count.
// RQ23: single-byte loading clears the other count byte to zero.
// RQ24: status byte is eight bits: output, null count, mode word.
// RQ25: each counter is a sixteen-bit down-counter loaded from a count register.
// RQ26: mode word: select 7:6, format 5:4, mode 3:1, decimal 0.
// RQ27: read-back selects counters in bits 3:1; null set on write, cleared on load.
`include "itm_timer_regs.vh"

module itm_timer (
   CLK_SYS,
   RST_N,
   CS_N,
   RD_N,
   WR_N,
   PORT_SELECT_LOW,
   PORT_SELECT_HIGH,
   DATA_IN,
   DATA_OUT,
   DATA_OE,
   CNT_CLK,
   CNT_GATE,
   CNT_OUT
);
   input  wire       CLK_SYS;
   input  wire       RST_N;
   input  wire       CS_N;
   input  wire       RD_N;
   input  wire       WR_N;
   input  wire       PORT_SELECT_LOW;
   input  wire       PORT_SELECT_HIGH;
   input  wire [7:0] DATA_IN;
   output reg  [7:0] DATA_OUT;
   output reg        DATA_OE;
   input  wire [2:0] CNT_CLK;
   input  wire [2:0] CNT_GATE;
   output wire [2:0] CNT_OUT;

   reg         rst_meta_reg;
   reg         rst_n_reg;
   reg         wr_q_reg;
   reg         rd_q_reg;
   reg  [1:0]  rd_sel_reg;
   wire [1:0]  addr;
   wire        wr_act;
   wire        rd_act;
   wire        wr_start;
   wire        rd_start;
   wire        rd_end;
   wire        cw_wr;
   wire        rb_cmd;
   wire [23:0] rd_bytes;

   // reset released through two flops
   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // strobe decode; both strobes low or chip deselected does nothing
   assign addr     = {PORT_SELECT_HIGH, PORT_SELECT_LOW};
   assign wr_act   = ~CS_N & ~WR_N & RD_N;
   // RQ3: no read at control
   assign rd_act   = ~CS_N & ~RD_N & WR_N & (addr != `ITM_ADDR_CTL);
   assign wr_start = wr_act & ~wr_q_reg;
   assign rd_start = rd_act & ~rd_q_reg;
   assign rd_end   = rd_q_reg & ~rd_act;
   assign cw_wr    = wr_start & (addr == `ITM_ADDR_CTL);
   assign rb_cmd   = cw_wr & (DATA_IN[`ITM_CW_SEL] == `ITM_SEL_READBACK);

   // read data captured at strobe start, bus driven while strobe lasts
   always @(posedge CLK_SYS or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         wr_q_reg   <= 1'b0;
         rd_q_reg   <= 1'b0;
         rd_sel_reg <= `ITM_ADDR_CNT0;
         DATA_OUT   <= `ITM_BYTE_ZERO;
         DATA_OE    <= 1'b0;
      end else begin
         wr_q_reg <= wr_act;
         rd_q_reg <= rd_act;
         // RQ3: drive bus on read
         DATA_OE  <= rd_act;
         if (rd_start) begin
            rd_sel_reg <= addr;
            DATA_OUT   <= rd_bytes[addr*8 +: 8];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_chan
         reg  [5:0]  ctl_reg;
         reg  [15:0] cr_reg;
         reg  [15:0] ol_reg;
         reg  [7:0]  st_reg;
         reg         latched_reg;
         reg         st_lat_reg;
         reg         wr_msb_reg;
         reg         rd_msb_reg;
         reg         null_reg;
         reg         pend_reg;
         reg         arm_reg;
         reg         run_reg;
         reg         hold_reg;
         reg         done_reg;
         reg         out_reg;
         reg         clk_prev_reg;
         reg         gate_reg;
         reg         trig_reg;
         reg         ld_w;
         reg         dec_w;
         reg  [7:0]  rd_b;
         wire [15:0] cnt;
         wire [2:0]  m;
         wire        fall;
         wire        rise;
         wire        tcr;
         wire        cnt_wr;
         wire        own_cw;
         wire        latch_cmd;
         wire        rb_sel;
         wire [15:0] rd_val;
         wire [7:0]  status;
         wire [15:0] ld_val;

         // modes 6 and 7 behave as 2 and 3
         assign m      = ctl_reg[2] ? {1'b0, ctl_reg[2:1]} : ctl_reg[3:1];
         // RQ15: falling edge acts
         assign fall   = clk_prev_reg & ~CNT_CLK[g];
         assign rise   = ~clk_prev_reg & CNT_CLK[g];
         // RQ17: reload point modes 2,3
         assign tcr    = run_reg & (cnt == ((m == `ITM_MODE3) ? `ITM_CNT_TWO : `ITM_CNT_ONE));
         assign cnt_wr = wr_start & (addr == g);
         // RQ26: mode word fields
         assign own_cw = cw_wr & (DATA_IN[`ITM_CW_SEL] == g);
         assign latch_cmd = own_cw & (DATA_IN[`ITM_CW_RW] == `ITM_RW_LATCH);
         // RQ27: read-back select bits
         assign rb_sel = rb_cmd & DATA_IN[`ITM_RB_CNT0 + g];
         // RQ24: status byte layout
         assign status = {out_reg, null_reg, ctl_reg};
         assign rd_val = latched_reg ? ol_reg : cnt;
         assign ld_val = (m == `ITM_MODE3) ? {cr_reg[15:1], 1'b0} : cr_reg;
         assign CNT_OUT[g] = out_reg;
         assign rd_bytes[g*8 +: 8] = rd_b;

         // RQ25: sixteen-bit down-counter
         itm_dcnt u_dcnt (
            .clk      (CLK_SYS),
            .rst_n    (rst_n_reg),
            .load     (ld_w),
            .dec      (dec_w),
            .step     ((m == `ITM_MODE3) ? `ITM_STEP_TWO : `ITM_STEP_ONE),
            .bcd      (ctl_reg[`ITM_CW_BCD]),
            .load_val (ld_val),
            .cnt      (cnt)
         );

         // load and decrement decisions for this falling edge
         always @* begin
            ld_w  = 1'b0;
            dec_w = 1'b0;
            if (fall) begin
               case (m)
                  `ITM_MODE0, `ITM_MODE4: begin
                     // RQ20: load next pulse
                     if (pend_reg) begin
                        ld_w = 1'b1;
                     end else if (run_reg & gate_reg & ~hold_reg) begin
                        dec_w = 1'b1;
                     end
                  end
                  `ITM_MODE1, `ITM_MODE5: begin
                     // RQ22: trigger loads
                     if (trig_reg & arm_reg) begin
                        ld_w = 1'b1;
                     end else if (run_reg) begin
                        dec_w = 1'b1;
                     end
                  end
                  `ITM_MODE2, `ITM_MODE3: begin
                     if (gate_reg & (trig_reg | (pend_reg & ~run_reg) | tcr)) begin
                        ld_w = 1'b1;
                     end else if (gate_reg & run_reg) begin
                        dec_w = 1'b1;
                     end
                  end
                  default: begin
                     ld_w  = 1'b0;
                     dec_w = 1'b0;
                  end
               endcase
            end
         end

         // read byte selection: status first, then count bytes
         always @* begin
            rd_b = rd_val[7:0];
            // RQ12: status read first
            if (st_lat_reg) begin
               rd_b = st_reg;
            end else if (ctl_reg[`ITM_CW_RW] == `ITM_RW_MSB) begin
               rd_b = rd_val[15:8];
            end else if ((ctl_reg[`ITM_CW_RW] == `ITM_RW_BOTH) & rd_msb_reg) begin
               rd_b = rd_val[15:8];
            end
         end

         // channel state: counter clock events, then read end, then writes
         always @(posedge CLK_SYS or negedge rst_n_reg) begin
            if (!rst_n_reg) begin
               ctl_reg      <= `ITM_CTL_RST;
               cr_reg       <= `ITM_CNT_RST;
               ol_reg       <= `ITM_CNT_RST;
               st_reg       <= `ITM_BYTE_ZERO;
               latched_reg  <= 1'b0;
               st_lat_reg   <= 1'b0;
               wr_msb_reg   <= 1'b0;
               rd_msb_reg   <= 1'b0;
               null_reg     <= 1'b0;
               pend_reg     <= 1'b0;
               arm_reg      <= 1'b0;
               run_reg      <= 1'b0;
               hold_reg     <= 1'b0;
               done_reg     <= 1'b0;
               out_reg      <= 1'b0;
               clk_prev_reg <= 1'b0;
               gate_reg     <= 1'b0;
               trig_reg     <= 1'b0;
            end else begin
               clk_prev_reg <= CNT_CLK[g];
               // RQ14: gate sampled on rise
               if (rise) begin
                  gate_reg <= CNT_GATE[g];
                  if (CNT_GATE[g] & ~gate_reg) begin
                     trig_reg <= 1'b1;
                  end
               end
               if (fall) begin
                  trig_reg <= 1'b0;
               end
               if (ld_w) begin
                  // RQ27: null cleared on load
                  pend_reg <= 1'b0;
                  null_reg <= 1'b0;
                  run_reg  <= 1'b1;
                  done_reg <= 1'b0;
               end
               // output per mode at falling edge
               if (fall) begin
                  case (m)
                     `ITM_MODE0: begin
                        // RQ19: gate leaves output
                        // RQ18: high at terminal count
                        if (dec_w & (cnt == `ITM_CNT_ONE)) begin
                           out_reg <= 1'b1;
                        end
                     end
                     `ITM_MODE1: begin
                        // RQ22: low on trigger load
                        if (ld_w) begin
                           out_reg <= 1'b0;
                        end else if (dec_w & (cnt == `ITM_CNT_ONE)) begin
                           out_reg <= 1'b1;
                        end
                     end
                     `ITM_MODE2: begin
                        if (ld_w) begin
                           out_reg <= 1'b1;
                        end else if (dec_w) begin
                           out_reg <= (cnt != `ITM_CNT_TWO);
                        end
                     end
                     `ITM_MODE3: begin
                        if (ld_w) begin
                           out_reg <= (tcr & ~trig_reg) ? ~out_reg : 1'b1;
                        end
                     end
                     `ITM_MODE4, `ITM_MODE5: begin
                        if (~out_reg) begin
                           out_reg <= 1'b1;
                        end else if (dec_w & ~done_reg & (cnt == `ITM_CNT_ONE)) begin
                           out_reg  <= 1'b0;
                           done_reg <= 1'b1;
                        end
                     end
                     default: begin
                        out_reg <= out_reg;
                     end
                  endcase
               end
               // gate low forces the output high at once in modes 2 and 3
               if (((m == `ITM_MODE2) | (m == `ITM_MODE3)) & ~CNT_GATE[g]) begin
                  out_reg <= 1'b1;
               end
               // read end steps the read toggle and releases latches
               if (rd_end & (rd_sel_reg == g)) begin
                  if (st_lat_reg) begin
                     st_lat_reg <= 1'b0;
                  end else if ((ctl_reg[`ITM_CW_RW] == `ITM_RW_BOTH) & ~rd_msb_reg) begin
                     // RQ8: read toggle separate
                     rd_msb_reg <= 1'b1;
                  end else begin
                     rd_msb_reg  <= 1'b0;
                     latched_reg <= 1'b0;
                  end
               end
               // count byte writes
               if (cnt_wr) begin
                  case (ctl_reg[`ITM_CW_RW])
                     `ITM_RW_LSB: begin
                        // RQ23: other byte cleared
                        cr_reg <= {`ITM_BYTE_ZERO, DATA_IN};
                     end
                     `ITM_RW_MSB: begin
                        cr_reg <= {DATA_IN, `ITM_BYTE_ZERO};
                     end
                     default: begin
                        if (~wr_msb_reg) begin
                           cr_reg[7:0] <= DATA_IN;
                        end else begin
                           cr_reg[15:8] <= DATA_IN;
                        end
                     end
                  endcase
                  if ((ctl_reg[`ITM_CW_RW] == `ITM_RW_BOTH) & ~wr_msb_reg) begin
                     wr_msb_reg <= 1'b1;
                     // RQ21: first byte suspends
                     if (m == `ITM_MODE0) begin
                        hold_reg <= 1'b1;
                        out_reg  <= 1'b0;
                     end
                  end else begin
                     wr_msb_reg <= 1'b0;
                     hold_reg   <= 1'b0;
                     null_reg   <= 1'b1;
                     arm_reg    <= 1'b1;
                     pend_reg   <= 1'b1;
                     // RQ18: new count, output low
                     if (m == `ITM_MODE0) begin
                        out_reg <= 1'b0;
                        run_reg <= 1'b0;
                     end
                  end
               end
               // RQ5: count latch command
               // RQ6: repeat latch ignored
               // RQ10: repeat ignored
               // RQ11: combined read-back latch
               if ((latch_cmd | (rb_sel & ~DATA_IN[`ITM_RB_NCOUNT])) & ~latched_reg) begin
                  ol_reg      <= cnt;
                  latched_reg <= 1'b1;
               end
               // RQ9: status latch
               if (rb_sel & ~DATA_IN[`ITM_RB_NSTATUS] & ~st_lat_reg) begin
                  st_reg     <= status;
                  st_lat_reg <= 1'b1;
               end
               // mode word programs the channel and drops old latches
               if (own_cw & ~latch_cmd) begin
                  ctl_reg     <= DATA_IN[`ITM_CW_KEEP];
                  // RQ13: initial output level
                  out_reg     <= (DATA_IN[`ITM_CW_MODE] != `ITM_MODE0);
                  null_reg    <= 1'b1;
                  pend_reg    <= 1'b0;
                  arm_reg     <= 1'b0;
                  run_reg     <= 1'b0;
                  hold_reg    <= 1'b0;
                  done_reg    <= 1'b0;
                  latched_reg <= 1'b0;
                  st_lat_reg  <= 1'b0;
                  wr_msb_reg  <= 1'b0;
                  rd_msb_reg  <= 1'b0;
               end
            end
         end
      end
   endgenerate
endmodule // itm_timer

// file: tb/itm_host.sv
// host bus model: strobed reads and writes on the timer port
module itm_host (
   input  wire logic       CLK_SYS,
   output logic            CS_N,
   output logic            RD_N,
   output logic            WR_N,
   output logic            PORT_SELECT_LOW,
   output logic            PORT_SELECT_HIGH,
   output logic      [7:0] DATA_IN,
   input  wire logic [7:0] DATA_OUT,
   input  wire logic       DATA_OE
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus at time zero
   initial begin
      {CS_N, RD_N, WR_N} = 3'h7;
      {PORT_SELECT_HIGH, PORT_SELECT_LOW} = 2'h0;
      DATA_IN = 8'h00;
   end

   // one access, s = {cs_n, rd_n, wr_n}, held two cycles from a falling edge
   task automatic cyc(input logic [2:0] s, input logic [1:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic oe);
      @(negedge CLK_SYS);
      {CS_N, RD_N, WR_N} = s;
      {PORT_SELECT_HIGH, PORT_SELECT_LOW} = a;
      DATA_IN = d;
      repeat (2) @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      q = DATA_OUT;
      oe = DATA_OE;
      {CS_N, RD_N, WR_N} = 3'h7;
      // released lines show the inverse of the last value
      DATA_IN = ~d;
      repeat (2) @(posedge CLK_SYS);
   endtask

   // register write
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic       oe;
      cyc(3'h2, a, d, q, oe);
   endtask
endmodule // itm_host

// file: tb/itm_timer_sva.sv
// concurrent checks on the timer's bus and counter pins
module itm_timer_sva (
   input wire       CLK_SYS,
   input wire       RST_N,
   input wire       CS_N,
   input wire       RD_N,
   input wire       WR_N,
   input wire       PORT_SELECT_LOW,
   input wire       PORT_SELECT_HIGH,
   input wire [7:0] DATA_IN,
   input wire [7:0] DATA_OUT,
   input wire       DATA_OE,
   input wire [2:0] CNT_CLK,
   input wire [2:0] CNT_GATE,
   input wire [2:0] CNT_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);
   // decoded bus cycles
   wire a3    = PORT_SELECT_LOW & PORT_SELECT_HIGH;
   wire rd_ok = !CS_N & !RD_N & WR_N & !a3;
   wire cw_wr = !CS_N & !WR_N & RD_N & a3;
   // bus drive, floating and read data
   property p_cs_float; CS_N |=> !DATA_OE; endproperty
   a_cs_float: assert property (p_cs_float) else $error("bus driven while deselected");
   property p_rd_idle; RD_N |=> !DATA_OE; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("bus driven without read");
   property p_a3_float; !RD_N && a3 |=> !DATA_OE; endproperty
   a_a3_float: assert property (p_a3_float) else $error("bus driven on mode port read");
   property p_both_float; !RD_N && !WR_N |=> !DATA_OE; endproperty
   a_both_float: assert property (p_both_float) else $error("bus driven with both strobes");
   property p_rd_drive; rd_ok ##1 rd_ok |-> DATA_OE; endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("counter read not driven");
   property p_out_hold; RD_N && $past(RD_N) |-> $stable(DATA_OUT); endproperty
   a_out_hold: assert property (p_out_hold) else $error("read data moved between reads");
   // counter output moves only on clock falls, writes or gate changes
   property p_cnt_hold;
      (CNT_CLK[0] && WR_N && $stable(CNT_GATE[0])) [*4] |-> $stable(CNT_OUT[0]);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold) else $error("output moved while clock high");
   // initial output level on mode setting
   property p_cw_m0;
      cw_wr && $past(WR_N) && DATA_IN[7:6] == 2'h0 && DATA_IN[5:4] != 2'h0 && DATA_IN[3:1] == 3'h0
         |-> ##[1:2] !CNT_OUT[0];
   endproperty
   a_cw_m0: assert property (p_cw_m0) else $error("mode 0 output not low");
   property p_cw_m1;
      cw_wr && $past(WR_N) && DATA_IN[7:6] == 2'h2 && DATA_IN[5:4] != 2'h0 && DATA_IN[3:1] == 3'h1
         |-> ##[1:2] CNT_OUT[2];
   endproperty
   a_cw_m1: assert property (p_cw_m1) else $error("mode 1 output not high");
   // main scenarios reached
   c_read: cover property (rd_ok ##1 DATA_OE);
   c_cw: cover property (cw_wr);
   c_tc: cover property ($rose(CNT_OUT[0]));
endmodule // itm_timer_sva

bind itm_timer itm_timer_sva itm_timer_sva_i (.CLK_SYS, .RST_N, .CS_N, .RD_N, .WR_N, .PORT_SELECT_LOW,
   .PORT_SELECT_HIGH, .DATA_IN, .DATA_OUT, .DATA_OE, .CNT_CLK, .CNT_GATE, .CNT_OUT);

// file: tb/tb.sv
// self-checking bench for the interval timer
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       CLK_SYS;
   logic       RST_N;
   wire        CS_N;
   wire        RD_N;
   wire        WR_N;
   wire        PORT_SELECT_LOW;
   wire        PORT_SELECT_HIGH;
   wire  [7:0] DATA_IN;
   wire  [7:0] DATA_OUT;
   wire        DATA_OE;
   logic [2:0] CNT_CLK;
   logic [2:0] CNT_GATE;
   wire  [2:0] CNT_OUT;
   int         mismatches = 0;
   int         n_compared = 0;
   logic [7:0] q;
   logic       oe;

   itm_timer itm_timer_i (.CLK_SYS, .RST_N, .CS_N, .RD_N, .WR_N, .PORT_SELECT_LOW, .PORT_SELECT_HIGH,
                          .DATA_IN, .DATA_OUT, .DATA_OE, .CNT_CLK, .CNT_GATE, .CNT_OUT);
   itm_host host (.CLK_SYS, .CS_N, .RD_N, .WR_N, .PORT_SELECT_LOW, .PORT_SELECT_HIGH,
                  .DATA_IN, .DATA_OUT, .DATA_OE);

   // 200 MHz system clock
   initial begin
      CLK_SYS = 1'b0;
      forever #2.5 CLK_SYS = ~CLK_SYS;
   end

   // compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // verdict and end of run
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // read a port and compare the byte
   task automatic rc(input logic [1:0] a, input logic [7:0] e);
      host.cyc(3'h1, a, 8'h00, q, oe);
      chk(q, e);
   endtask

   // settle, then compare one counter output
   task automatic ck_out(input int k, input logic e);
      repeat (3) @(negedge CLK_SYS);
      chk({7'h00, CNT_OUT[k]}, {7'h00, e});
   endtask

   // counter clock pulses, five system cycles high and low
   task automatic pulse(input int k, input int n);
      repeat (n) begin
         @(negedge CLK_SYS);
         CNT_CLK[k] = 1'b1;
         repeat (5) @(negedge CLK_SYS);
         CNT_CLK[k] = 1'b0;
         repeat (5) @(negedge CLK_SYS);
      end
   endtask

   // gate level change on a falling edge
   task automatic gate(input int k, input logic v);
      @(negedge CLK_SYS);
      CNT_GATE[k] = v;
   endtask

   // floating bus on mode port read, deselect, both strobes
   task automatic t_float;
      host.cyc(3'h1, 2'h3, 8'h00, q, oe);
      chk({7'h00, oe}, 8'h00);
      host.cyc(3'h5, 2'h0, 8'h00, q, oe);
      chk({7'h00, oe}, 8'h00);
      host.cyc(3'h0, 2'h0, 8'h00, q, oe);
      chk({7'h00, oe}, 8'h00);
      host.cyc(3'h1, 2'h1, 8'h00, q, oe);
      chk({7'h00, oe}, 8'h01);
   endtask

   // mode 0: low on setting, paused by gate, high at terminal count
   task automatic t_mode0;
      host.wr(2'h3, 8'h30);
      ck_out(0, 1'b0);
      host.wr(2'h0, 8'h03);
      host.wr(2'h0, 8'h00);
      pulse(0, 3);
      ck_out(0, 1'b0);
      gate(0, 1'b1);
      pulse(0, 2);
      ck_out(0, 1'b0);
      pulse(0, 1);
      ck_out(0, 1'b1);
      gate(0, 1'b0);
      ck_out(0, 1'b1);
      gate(0, 1'b1);
   endtask

   // latch freezes, repeat ignored, read and write toggles apart
   task automatic t_latch;
      host.wr(2'h3, 8'h00);
      pulse(0, 1);
      host.wr(2'h3, 8'h00);
      rc(2'h0, 8'h00);
      rc(2'h0, 8'h00);
      // counter clock held still for plain reads
      rc(2'h0, 8'hFF);
      host.wr(2'h0, 8'h10);
      ck_out(0, 1'b0);
      rc(2'h0, 8'hFF);
      host.wr(2'h0, 8'h00);
      pulse(0, 1);
      rc(2'h0, 8'h10);
      rc(2'h0, 8'h00);
   endtask

   // read-back: status first, repeats ignored, null count flag
   task automatic t_rdbk;
      pulse(0, 1);
      host.wr(2'h3, 8'hC2);
      pulse(0, 1);
      host.wr(2'h3, 8'hC2);
      rc(2'h0, 8'h30);
      rc(2'h0, 8'h0F);
      rc(2'h0, 8'h00);
      host.wr(2'h0, 8'h05);
      host.wr(2'h0, 8'h00);
      host.wr(2'h3, 8'hE2);
      rc(2'h0, 8'h70);
      pulse(0, 1);
      host.wr(2'h3, 8'hE2);
      rc(2'h0, 8'h30);
   endtask

   // single-byte load clears the other count byte
   task automatic t_single;
      host.wr(2'h3, 8'h60);
      host.wr(2'h1, 8'h01);
      host.wr(2'h3, 8'h50);
      host.wr(2'h1, 8'h05);
      pulse(1, 5);
      ck_out(1, 1'b0);
      pulse(1, 1);
      ck_out(1, 1'b1);
   endtask

   // mode 1: high on setting, low once triggered
   task automatic t_mode1;
      host.wr(2'h3, 8'hB2);
      ck_out(2, 1'b1);
      host.wr(2'h2, 8'h04);
      host.wr(2'h2, 8'h00);
      gate(2, 1'b0);
      pulse(2, 1);
      ck_out(2, 1'b1);
      gate(2, 1'b1);
      pulse(2, 2);
      ck_out(2, 1'b0);
   endtask

   // watchdog against a hang
   initial begin
      #20000;
      mismatches++;
      final_report;
   end

   // reset, then the scenarios in order
   initial begin
      CNT_CLK = 3'h0;
      CNT_GATE = 3'h6;
      RST_N = 1'b0;
      repeat (4) @(negedge CLK_SYS);
      RST_N = 1'b1;
      repeat (3) @(negedge CLK_SYS);
      t_float;
      t_mode0;
      t_latch;
      t_rdbk;
      t_single;
      t_mode1;
      final_report;
   end
endmodule // tb
